// *** common/odu_pkg.sv ***
`default_nettype none
package odu_pkg;

    // decoded view of one fetched opcode
    typedef struct packed {
        logic valid;
        logic undef;
        logic [1:0] len;
        logic [3:0] cycles;
        logic endless;
    } odu_dec_t;

    // where the current core address lands
    typedef struct packed {
        logic rom_sel;
        logic unusable;
        logic open_map;
    } odu_map_t;

    localparam int UNDEF_COUNT = 36;
    localparam logic [7:0] OPC_TEST_A = 8'h4e;
    localparam logic [7:0] OPC_TEST_B = 8'h5e;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [3:0] CYC_NONE = 4'h0;

    // base bytes and cycles per upper-nibble column, column f first
    localparam logic [15:0][1:0] COL_LEN = {
        2'h3, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2,
        2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
    localparam logic [15:0][3:0] COL_CYC = {
        4'h4, 4'h4, 4'h3, 4'h2, 4'h4, 4'h4, 4'h3, 4'h2,
        4'h6, 4'h6, 4'h2, 4'h2, 4'h3, 4'h3, 4'h2, 4'h2};

    localparam logic [15:0] ROM_LO_CFG0 = 16'hf800;
    localparam logic [15:0] ROM_LO_CFG1 = 16'hf000;
    localparam logic [15:0] UNUSE_LO = 16'he000;

    localparam odu_dec_t DEC_RST = '0;
    localparam odu_map_t MAP_RST = '0;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [15:0] PC_RST = 16'h0000;

endpackage : odu_pkg
`default_nettype wire

// *** hw/odu_addr_map.sv ***
`default_nettype none
module odu_addr_map
    import odu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] addr,
    input wire logic cfg,
    output var odu_map_t map
);

    typedef struct packed {
        odu_map_t map;
    } odu_map_st_t;

    odu_map_st_t st_r;
    odu_map_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // see RULE6 see RULE7
        st_nxt.map.rom_sel = cfg ? (addr >= ROM_LO_CFG1) : (addr >= ROM_LO_CFG0);
        st_nxt.map.unusable = (addr >= UNUSE_LO) && !st_nxt.map.rom_sel;
        st_nxt.map.open_map = (addr < UNUSE_LO);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{map: MAP_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign map = st_r.map;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_rom_cfg0: assert property ( // see RULE6
        !cfg && addr >= ROM_LO_CFG0 |=> map.rom_sel && !map.unusable)
        else $error("rom not selected in first configuration");
    chk_unuse_cfg0: assert property ( // see RULE6
        !cfg && addr >= UNUSE_LO && addr < ROM_LO_CFG0 |=> map.unusable && !map.rom_sel)
        else $error("gap below rom not marked unusable");
    chk_rom_cfg1: assert property ( // see RULE7
        cfg && addr >= UNUSE_LO |=> (map.rom_sel == ($past(addr) >= ROM_LO_CFG1))
            && (map.unusable != map.rom_sel))
        else $error("second configuration map wrong");
    cov_rom_cfg1: cover property (cfg && addr == ROM_LO_CFG1 ##1 map.rom_sel);

endmodule // odu_addr_map
`default_nettype wire

// *** hw/odu_decode.sv ***
// What this block does
// RULE1: exactly 36 opcodes are undefined; their results are not defined.
// RULE2: test opcodes 4e and 5e keep stepping the program counter until reset.
// RULE3: test opcodes are one byte long with no ending cycle count.
// RULE4: total cycles are the column base plus the opcode's extra figure.
// RULE5: immediate 16-bit forms and undefined 8f, cd, cf take three bytes.
// RULE6: first configuration: rom at f800-ffff, e000-f7ff unusable.
// RULE7: second configuration: rom at f000-ffff, e000 upward unusable otherwise.
// RULE8: upper nibble picks the column giving base length and cycles.
`default_nettype none
module odu_decode
    import odu_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic OPC_VALID,
    input wire logic [7:0] OPC,
    input wire logic [15:0] PC_IN,
    input wire logic CFG_PIN,
    input wire logic [15:0] ADDR,
    output var odu_dec_t DEC,
    output logic TEST_RUN,
    output logic PC_STEP,
    output logic [15:0] PC_OUT,
    output var odu_map_t MAP
);

    function automatic logic is_test(input logic [7:0] op);
        return (op == OPC_TEST_A) || (op == OPC_TEST_B);
    endfunction

    function automatic logic is_undef(input logic [7:0] op);
        logic u;
        u = 1'b0;
        unique case (op)
            8'h00, 8'h02, 8'h03,
            8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h1a, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
            8'h41, 8'h42, 8'h45, 8'h4b, 8'h4e,
            8'h51, 8'h52, 8'h55, 8'h5b, 8'h5e,
            8'h61, 8'h62, 8'h65, 8'h6b,
            8'h71, 8'h72, 8'h75, 8'h7b,
            8'h87, 8'h8f, 8'hc7, 8'hcd, 8'hcf: u = 1'b1;
            default: u = 1'b0;
        endcase
        return u;
    endfunction

    // sub_double_acc, compare_index, load_stack_ptr immediate, add_double_acc,
    // load_double_acc, load_index immediate and three undefined codes
    function automatic logic three_byte(input logic [7:0] op);
        logic t;
        t = 1'b0;
        unique case (op)
            8'h83, 8'h8c, 8'h8e, 8'hc3, 8'hcc, 8'hce,
            8'h8f, 8'hcd, 8'hcf: t = 1'b1;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // extra cycles in two's complement; wraps mod 16 so the jump's -3 subtracts
    function automatic logic [3:0] extra(input logic [7:0] op);
        logic [3:0] e;
        e = 4'h0;
        unique case (op)
            8'h04, 8'h05, 8'h08, 8'h09, 8'h32, 8'h33, 8'h3c,
            8'h8e, 8'h9e, 8'hae, 8'hbe, 8'hcc, 8'hdc, 8'hec, 8'hfc,
            8'hce, 8'hde, 8'hee, 8'hfe, 8'hdd, 8'hed, 8'hfd,
            8'h9f, 8'haf, 8'hbf, 8'hdf, 8'hef, 8'hff,
            8'h8f, 8'hcd, 8'hcf: e = 4'h1;
            8'h38, 8'h39,
            8'h83, 8'h93, 8'ha3, 8'hb3, 8'hc3, 8'hd3, 8'he3, 8'hf3,
            8'h8c, 8'h9c, 8'hac, 8'hbc: e = 4'h2;
            8'h8d: e = 4'h4;
            8'h3e: e = 4'h6;
            8'h3b, 8'h3d: e = 4'h7;
            8'h3f: e = 4'h9;
            8'h6e, 8'h7e: e = 4'hd;
            default: e = 4'h0;
        endcase
        return e;
    endfunction

    function automatic odu_dec_t decode(input logic [7:0] op);
        odu_dec_t d;
        logic [3:0] col;
        d = DEC_RST;
        col = op[7:4]; // see RULE8
        d.valid = 1'b1;
        d.undef = is_undef(op); // see RULE1
        d.len = COL_LEN[col]; // see RULE8
        d.cycles = 4'(COL_CYC[col] + extra(op)); // see RULE4
        if (three_byte(op)) begin
            d.len = LEN_THREE; // see RULE5
        end
        if (is_test(op)) begin
            d.len = LEN_ONE; // see RULE3
            d.cycles = CYC_NONE;
            d.endless = 1'b1;
        end
        return d;
    endfunction

    function automatic int count_undef();
        int n;
        n = 0;
        for (int i = 0; i < 256; i++) begin
            if (is_undef(8'(i))) begin
                n++;
            end
        end
        return n;
    endfunction

    localparam int N_UNDEF = count_undef();

    typedef struct packed {
        logic [2:0] sync;
        logic cfg;
        logic test;
        logic [15:0] pc;
        odu_dec_t dec;
    } odu_core_t;

    odu_core_t st_r;
    odu_core_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // config strap is a pin: three stages, accepted once the last two agree
        st_nxt.sync = {st_r.sync[1:0], CFG_PIN};
        if (st_r.sync[1] == st_r.sync[2]) begin
            st_nxt.cfg = st_r.sync[2];
        end
        st_nxt.dec.valid = 1'b0;
        if (st_r.test) begin
            // only reset leaves this; fetches are ignored meanwhile
            st_nxt.pc = st_r.pc + 16'h0001; // see RULE2
        end else if (OPC_VALID) begin
            st_nxt.dec = decode(OPC);
            if (is_test(OPC)) begin
                st_nxt.test = 1'b1; // see RULE2
                st_nxt.pc = PC_IN + 16'h0001; // see RULE3
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '{sync: SYNC_RST, cfg: 1'b0, test: 1'b0, pc: PC_RST, dec: DEC_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign DEC = st_r.dec;
    assign TEST_RUN = st_r.test;
    assign PC_STEP = st_r.test;
    assign PC_OUT = st_r.pc;

    // map decode follows the filtered strap, never the raw pin
    odu_addr_map u_map (
        .clk(CLK),
        .nrst(NRST),
        .addr(ADDR),
        .cfg(st_r.cfg),
        .map(MAP)
    );

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_undef_count: assert property (N_UNDEF == UNDEF_COUNT) // see RULE1
        else $error("undefined opcode set is not 36 entries");
    chk_undef_flag: assert property ( // see RULE1
        OPC_VALID && !TEST_RUN |=> DEC.valid && (DEC.undef == is_undef($past(OPC))))
        else $error("undefined flag wrong after fetch");
    chk_test_enter: assert property ( // see RULE2
        OPC_VALID && !TEST_RUN && is_test(OPC) |=> TEST_RUN && PC_OUT == $past(PC_IN) + 16'h0001)
        else $error("test opcode did not start pc stepping");
    chk_test_hold: assert property ( // see RULE2
        TEST_RUN |=> TEST_RUN && PC_STEP && PC_OUT == $past(PC_OUT) + 16'h0001 ##1 TEST_RUN)
        else $error("pc stepping stopped without reset");
    chk_test_len: assert property ( // see RULE3
        $rose(TEST_RUN) |-> DEC.len == LEN_ONE && DEC.endless && DEC.cycles == CYC_NONE
            ##1 !DEC.valid [*3])
        else $error("test opcode length or cycles wrong");
    chk_cycles_sum: assert property ( // see RULE4
        OPC_VALID && !TEST_RUN && !is_test(OPC)
        |=> DEC.cycles == 4'(COL_CYC[$past(OPC[7:4])] + extra($past(OPC))) && !DEC.endless)
        else $error("cycle total is not base plus extra");
    chk_three_byte: assert property ( // see RULE5
        OPC_VALID && !TEST_RUN && three_byte(OPC) |=> DEC.len == LEN_THREE)
        else $error("three byte opcode not lengthened");
    chk_col_len: assert property ( // see RULE8
        OPC_VALID && !TEST_RUN && !three_byte(OPC) && !is_test(OPC)
        |=> DEC.len == COL_LEN[$past(OPC[7:4])])
        else $error("base length does not follow column");

    cov_test_run: cover property (OPC_VALID && OPC == OPC_TEST_B ##1 TEST_RUN [*4]);
    cov_undef: cover property (OPC_VALID && !TEST_RUN && is_undef(OPC) ##1 DEC.undef);
    cov_three: cover property (OPC_VALID && !TEST_RUN && OPC == 8'hcf ##1 DEC.len == LEN_THREE);
    cov_cfg_flip: cover property ($rose(st_r.cfg));

endmodule // odu_decode
`default_nettype wire

// *** bench/odu_prog_mem.sv ***
`default_nettype none
module odu_prog_mem
    import odu_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic cfg,
    output logic hit,
    output logic [7:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last = 8'h00;
    // rom window moves with the strap
    assign hit = addr >= (cfg ? ROM_LO_CFG1 : ROM_LO_CFG0);
    // unselected bus shows the inverse so stale bytes never pass
    assign data = hit ? addr[7:0] : ~last;
    // window tested here directly, not through hit, to avoid an update race
    always @(addr or cfg) begin
        if (addr >= (cfg ? ROM_LO_CFG1 : ROM_LO_CFG0)) last = addr[7:0];
    end
endmodule // odu_prog_mem
`default_nettype wire

// *** bench/opcode_decode_undefined_ops_bench.sv ***
`default_nettype none
module opcode_decode_undefined_ops_bench import odu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // bytes per column, column 0 in the top nibble
    localparam logic [63:0] COL_BYTES = 64'h1121_1123_2223_2223;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic opc_valid = 1'b0;
    logic [7:0] opc = 8'h00;
    logic [15:0] pc_in = 16'h0000;
    logic cfg_pin = 1'b0;
    logic [15:0] addr = 16'h0000;
    odu_dec_t dec;
    odu_map_t map;
    logic test_run;
    logic pc_step;
    logic [15:0] pc_out;
    logic pm_hit;
    logic [7:0] pm_data;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    odu_decode i_dut (.CLK(clk), .NRST(nrst), .OPC_VALID(opc_valid), .OPC(opc),
        .PC_IN(pc_in), .CFG_PIN(cfg_pin), .ADDR(addr), .DEC(dec), .TEST_RUN(test_run),
        .PC_STEP(pc_step), .PC_OUT(pc_out), .MAP(map));
    odu_prog_mem i_mem (.addr(addr), .cfg(cfg_pin), .hit(pm_hit), .data(pm_data));

    always #12.5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        opc_valid <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        // strap sync needs four edges
        repeat (4) @(posedge clk);
    endtask

    // opcode byte comes from the program memory at a
    task automatic fetch(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        opc <= pm_data;
        pc_in <= a;
        opc_valid <= 1'b1;
        @(posedge clk);
        opc_valid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_opcodes();
        int n;
        int col;
        logic [3:0] cyc_exp;
        n = 0;
        for (int i = 0; i < 256; i++) begin
            if (i == 8'h4e || i == 8'h5e) continue;
            col = i >> 4;
            fetch({8'hf8, i[7:0]});
            check(dec.valid, 16'h1, "valid");
            check(dec.endless, 16'h0, "endless");
            if (dec.undef === 1'b1) n++;
            if (i inside {'h83, 'h8c, 'h8e, 'hc3, 'hcc, 'hce, 'h8f, 'hcd, 'hcf}) begin
                check(dec.len, 16'h3, "len three");
            end else if (dec.undef === 1'b0) begin
                check(dec.len, COL_BYTES[63 - 4*col -: 4], "len col");
            end
            case (i)
                'h83, 'h8c: cyc_exp = 4'h4;
                'h3b, 'h3d: cyc_exp = 4'ha;
                'h3f: cyc_exp = 4'hc;
                'h3e: cyc_exp = 4'h9;
                'h6e, 'h7e: cyc_exp = 4'h3;
                'hf3: cyc_exp = 4'h6;
                'h01: cyc_exp = 4'h2;
                'hb6: cyc_exp = 4'h4;
                default: cyc_exp = 4'h0;
            endcase
            if (cyc_exp != 4'h0) check(dec.cycles, cyc_exp, "cycles");
        end
        check(n, 16'd34, "undef count");
    endtask

    task automatic t_map(input logic c);
        logic [15:0] a[8] = '{16'h0000, 16'hdfff, 16'he000, 16'hefff,
            16'hf000, 16'hf7ff, 16'hf800, 16'hffff};
        @(posedge clk);
        cfg_pin <= c;
        repeat (4) @(posedge clk);
        foreach (a[i]) begin
            @(posedge clk);
            addr <= a[i];
            @(posedge clk);
            @(negedge clk);
            check({map.rom_sel, map.unusable, map.open_map},
                {pm_hit, a[i] >= 16'he000 && !pm_hit, a[i] < 16'he000}, "map");
        end
    endtask

    // a wraps past ffff when started high enough
    task automatic t_test(input logic [15:0] a);
        do_reset();
        fetch(a);
        check({dec.valid, dec.undef, dec.endless}, 16'h7, "test flags");
        check({dec.len, dec.cycles}, {10'h0, LEN_ONE, CYC_NONE}, "test size");
        check({test_run, pc_step}, 16'h3, "run");
        check(pc_out, a + 16'h1, "pc entry");
        for (int k = 2; k < 170; k++) begin
            @(posedge clk);
            opc <= 8'h01;
            opc_valid <= 1'b1;
            @(negedge clk);
            check(pc_out, a + k[15:0], "pc step");
            check({dec.valid, test_run}, 16'h1, "fetch ignored");
        end
        @(posedge clk);
        nrst <= 1'b0;
        opc_valid <= 1'b0;
        @(negedge clk);
        check({15'h0, test_run}, 16'h0, "reset exit run");
        check(pc_out, 16'h0, "reset exit pc");
    endtask

    initial begin
        do_reset();
        t_opcodes();
        t_map(1'b0);
        t_map(1'b1);
        t_test(16'hf84e);
        t_test(16'hff5e);
        end_of_test();
    end
endmodule // opcode_decode_undefined_ops_bench
`default_nettype wire
